// >>> arithmetic_unit_control_bench.sv
// testbench for the arithmetic unit control block
// assumes auc_core, auc_cpu_model and the checker are compiled before
`timescale 1ns/1ps
`default_nettype none
module arithmetic_unit_control_bench;
   logic        clk_in    = 1'b0;
   logic        rstn_in   = 1'b0;
   logic        clk_en_in = 1'b1;
   wire  [7:0]  addr;
   wire  [7:0]  wdata;
   wire  [7:0]  rdata;
   wire         wr_strb;
   wire  [31:0] res;
   wire         divm;
   wire         irq;
   int          error_cnt  = 0;
   int          n_compared = 0;
   int          cycles     = 0;

   always #5 clk_in = ~clk_in;

   auc_cpu_model cpu_u (.clk_in(clk_in), .sfr_rdata_in(rdata), .sfr_addr_out(addr),
                        .sfr_wr_out(wr_strb), .sfr_wdata_out(wdata));
   auc_core dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in), .sfr_addr_in(addr),
                   .sfr_wr_in(wr_strb), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .result_out(res),
                   .divider_mode_out(divm), .irq_out(irq));

   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         error_cnt++;
         conclude();
      end
   end

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cpu_u.wr_byte(a, d);
   endtask

   task automatic w16(input logic [7:0] a, input logic [15:0] v);
      wr(a + 8'h01, v[15:8]);
      wr(a, v[7:0]);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      cpu_u.rd_byte(a, v);
      cmp($sformatf("register %h", a), {24'h0, exp}, {24'h0, v});
   endtask

   task automatic rchk(input logic [31:0] exp);
      repeat (3) @(posedge clk_in);
      #1 cmp("result", exp, res);
   endtask

   task automatic pins(input logic [1:0] exp);
      cmp("mode and interrupt", {30'h0, exp}, {30'h0, divm, irq});
   endtask

   initial
   begin
      repeat (5) @(posedge clk_in);
      rstn_in <= 1'b1;
      rd(8'hc2, 8'h00);
      rd(8'hc3, 8'h00);
      rd(8'h00, 8'h00);
      w16(8'ha2, 16'h0003);
      w16(8'hb2, 16'h0005);
      rchk(32'h0000000f);
      wr(8'hc2, 8'h01);
      rchk(32'h00000009);
      wr(8'hc2, 8'h03);
      rchk(32'h0000000f);
      wr(8'ha4, 8'h00);
      wr(8'ha5, 8'h00);
      wr(8'ha6, 8'h01);
      wr(8'ha7, 8'h00);
      wr(8'hc2, 8'h04);
      rchk(32'h0001000f);
      wr(8'hc2, 8'h0c);
      rchk(32'h00040005);
      wr(8'hc2, 8'hcc);
      rd(8'hc2, 8'h4c);
      wr(8'hc2, 8'h58);
      rchk(32'h00040005);
      wr(8'hc2, 8'h48);
      rchk(32'h00040014);
      wr(8'hc2, 8'h42);
      rchk(32'h0000000f);
      wr(8'hc2, 8'h00);
      wr(8'ha2, 8'h04);
      rd(8'hd8, 8'h0f);
      rchk(32'h00000014);
      wr(8'hc2, 8'h0c);
      rchk(32'h00050005);
      wr(8'hc3, 8'he0);
      rchk(32'h00050005);
      wr(8'hc3, 8'h20);
      rchk(32'h00010005);
      wr(8'hc3, 8'h40);
      rchk(32'h00010000);
      wr(8'hc3, 8'h60);
      rchk(32'h00000000);
      rd(8'hc3, 8'h00);
      wr(8'hc3, 8'h80);
      rd(8'hd8, 8'h00);
      wr(8'hc2, 8'h6c);
      wr(8'ha4, 8'h02);
      w16(8'ha2, 16'hffff);
      w16(8'hb2, 16'hffff);
      rd(8'hc3, 8'h03);
      rd(8'hd8, 8'h01);
      wr(8'hb2, 8'h00);
      rd(8'hc3, 8'h03);
      wr(8'hc2, 8'h4c);
      wr(8'ha4, 8'h03);
      wr(8'hb2, 8'hff);
      rd(8'hd8, 8'h01);
      rchk(32'h00000002);
      wr(8'hb3, 8'h00);
      wr(8'hc3, 8'hc0);
      rd(8'hc3, 8'h00);
      wr(8'hc3, 8'h10);
      w16(8'ha2, 16'hfff9);
      wr(8'hb3, 8'h00);
      cpu_u.div_lo(8'h00);
      rchk(32'h00000000);
      pins(2'b11);
      rd(8'hc3, 8'h14);
      cpu_u.div_lo(8'h02);
      rchk(32'hfffffffd);
      wr(8'hc3, 8'hd0);
      rd(8'hc3, 8'h10);
      pins(2'b10);
      w16(8'ha2, 16'h8000);
      wr(8'hb3, 8'hff);
      cpu_u.div_lo(8'hff);
      rd(8'hc3, 8'h14);
      pins(2'b11);
      wr(8'hc3, 8'h00);
      rd(8'hc3, 8'h04);
      pins(2'b10);
      wr(8'hb2, 8'hff);
      rd(8'hc3, 8'h06);
      pins(2'b00);
      wr(8'hc3, 8'ha0);
      rd(8'hc3, 8'h00);
      rchk(32'h00000000);
      rd(8'hd8, 8'h00);
      @(posedge clk_in);
      clk_en_in <= 1'b0;
      wr(8'hc2, 8'h01);
      clk_en_in <= 1'b1;
      rd(8'hc2, 8'h4c);
      conclude();
   end
endmodule
`default_nettype wire

// >>> auc_core.v
// arithmetic unit control and status registers with operand storage
// assumes a single-cycle sfr write strobe from the core on clk_in
`timescale 1ns/1ps
`default_nettype none
`include "auc_defs.vh"

//Contract
//- manual mode, capture-now copies result; reads zero
//- auto mode captures on low byte write of operand a only
//- overflow capture enable stores result on 32-bit overflow
//- read-stored select picks previous over current
//- adder source: zero, c, previous, c
//- source 11 adds concatenated a and b
//- multiply select: ab, aa, a-prev, ab
//- divider mode zeroes multiplier inputs
//- multiplier mode: dividend zero, divisor one
//- clear command write-only, clears single registers
//- 101 clears operands, previous, divider mode and flags, 110 flags only
//- interrupt only when enabled, divider mode
//- range error on zero or overflow divide
//- 16-bit flag on carry 15 or 31
//- 32-bit flag when result exceeds 32 bits
//- alias divisor byte write enters divider mode
//- a upper, b lower when concatenated
//- a,b 16 bits; c, result, previous 32
//- result follows operands, no start command
module auc_core
(
   input  wire        clk_in,
   input  wire        rstn_in,
   input  wire        clk_en_in,
   input  wire [7:0]  sfr_addr_in,
   input  wire        sfr_wr_in,
   input  wire [7:0]  sfr_wdata_in,
   output wire [7:0]  sfr_rdata_out,
   output wire [31:0] result_out,
   output wire        divider_mode_out,
   output wire        irq_out
);

   reg  [6:0]  cfg1_reg;
   reg         unit_irq_en_reg;
   reg         divide_range_error_reg;
   reg         overflow16_flag_reg;
   reg         overflow32_flag_reg;
   reg         divider_mode_reg;
   reg  [15:0] operand_a_reg;
   reg  [15:0] operand_b_reg;
   reg  [31:0] operand_c_reg;
   reg  [31:0] previous_result_reg;
   reg  [31:0] result_reg;
   reg         eval_reg;
   reg  [7:0]  rdata_reg;
   reg         irq_reg;

   reg  [6:0]  cfg1_next;
   reg         irq_en_next;
   reg         range_next;
   reg         ov16_next;
   reg         ov32_next;
   reg         div_mode_next;
   reg  [15:0] a_next;
   reg  [15:0] b_next;
   reg  [31:0] c_next;
   reg  [31:0] prev_next;
   reg         eval_next;
   reg  [7:0]  rdata_next;
   reg         capture;
   reg         clr_flags;

   wire        wr;
   wire [2:0]  operand_clear_cmd;
   wire        capture_manual_sel;
   wire        capture_on_overflow_en;
   wire        read_stored_sel;
   wire [1:0]  adder_source_sel;
   wire [1:0]  multiply_operand_sel;
   wire [31:0] math_result;
   wire        math_ov16;
   wire        math_ov32;
   wire        math_range;

   // byte lane of a word
   function [7:0] get_byte;
      input [31:0] word;
      input [1:0]  idx;
      begin
         get_byte = word[idx*8 +: 8];
      end
   endfunction

   // replace one byte lane of a word
   function [31:0] put_byte;
      input [31:0] word;
      input [1:0]  idx;
      input [7:0]  data;
      begin
         put_byte = word;
         put_byte[idx*8 +: 8] = data;
      end
   endfunction

   assign wr                     = sfr_wr_in & clk_en_in;
   assign operand_clear_cmd      = sfr_wdata_in[`AUC_CFG2_CLR_HI:`AUC_CFG2_CLR_LO];
   assign capture_manual_sel     = cfg1_reg[`AUC_CFG1_CAP_MAN];
   assign capture_on_overflow_en = cfg1_reg[`AUC_CFG1_OV_CAP];
   assign read_stored_sel        = cfg1_reg[`AUC_CFG1_RD_STORE];
   assign adder_source_sel       = cfg1_reg[`AUC_CFG1_ADD_HI:`AUC_CFG1_ADD_LO];
   assign multiply_operand_sel   = cfg1_reg[`AUC_CFG1_MUL_HI:`AUC_CFG1_MUL_LO];

   auc_math u_math
   (
      .operand_a_in            (operand_a_reg),
      .operand_b_in            (operand_b_reg),
      .operand_c_in            (operand_c_reg),
      .previous_result_in      (previous_result_reg),
      .adder_source_sel_in     (adder_source_sel),
      .multiply_operand_sel_in (multiply_operand_sel),
      .divider_mode_in         (divider_mode_reg),
      .math_result_out         (math_result),
      .overflow16_out          (math_ov16),
      .overflow32_out          (math_ov32),
      .range_error_out         (math_range)
   );

   // register writes and captures
   always @*
   begin
      cfg1_next     = cfg1_reg;
      irq_en_next   = unit_irq_en_reg;
      div_mode_next = divider_mode_reg;
      a_next        = operand_a_reg;
      b_next        = operand_b_reg;
      c_next        = operand_c_reg;
      prev_next     = previous_result_reg;
      eval_next     = 1'b0;
      capture       = 1'b0;
      clr_flags     = 1'b0;
      if (wr)
      begin
         case (sfr_addr_in)
            `AUC_ADDR_CFG1:
            begin
               cfg1_next = sfr_wdata_in[6:0];
               eval_next = 1'b1;
               if (sfr_wdata_in[`AUC_CFG1_CAP_NOW] & sfr_wdata_in[`AUC_CFG1_CAP_MAN])
               begin
                  capture = 1'b1;
               end
            end
            `AUC_ADDR_CFG2:
            begin
               irq_en_next = sfr_wdata_in[`AUC_CFG2_IRQ_EN];
               case (operand_clear_cmd)
                  `AUC_CLR_A:     a_next = 16'h0000;
                  `AUC_CLR_B:     b_next = 16'h0000;
                  `AUC_CLR_C:     c_next = 32'h00000000;
                  `AUC_CLR_PREV:  prev_next = 32'h00000000;
                  `AUC_CLR_ALL:
                  begin
                     a_next        = 16'h0000;
                     b_next        = 16'h0000;
                     c_next        = 32'h00000000;
                     prev_next     = 32'h00000000;
                     div_mode_next = 1'b0;
                     clr_flags     = 1'b1;
                  end
                  `AUC_CLR_FLAGS: clr_flags = 1'b1;
                  default:        clr_flags = 1'b0;
               endcase
               eval_next = 1'b1;
            end
            `AUC_ADDR_A0:
            begin
               a_next    = {operand_a_reg[15:8], sfr_wdata_in};
               eval_next = 1'b1;
               if (!capture_manual_sel)
               begin
                  capture = 1'b1;
               end
            end
            `AUC_ADDR_A1:
            begin
               a_next    = {sfr_wdata_in, operand_a_reg[7:0]};
               eval_next = 1'b1;
            end
            `AUC_ADDR_B0:
            begin
               b_next        = {operand_b_reg[15:8], sfr_wdata_in};
               div_mode_next = 1'b0;
               eval_next     = 1'b1;
            end
            `AUC_ADDR_B0_DIV:
            begin
               b_next        = {operand_b_reg[15:8], sfr_wdata_in};
               div_mode_next = 1'b1;
               eval_next     = 1'b1;
            end
            `AUC_ADDR_B1:
            begin
               b_next    = {sfr_wdata_in, operand_b_reg[7:0]};
               eval_next = 1'b1;
            end
            `AUC_ADDR_C0:
            begin
               c_next    = put_byte(operand_c_reg, 2'd0, sfr_wdata_in);
               eval_next = 1'b1;
            end
            `AUC_ADDR_C1:
            begin
               c_next    = put_byte(operand_c_reg, 2'd1, sfr_wdata_in);
               eval_next = 1'b1;
            end
            `AUC_ADDR_C2:
            begin
               c_next    = put_byte(operand_c_reg, 2'd2, sfr_wdata_in);
               eval_next = 1'b1;
            end
            `AUC_ADDR_C3:
            begin
               c_next    = put_byte(operand_c_reg, 2'd3, sfr_wdata_in);
               eval_next = 1'b1;
            end
            default:
            begin
               eval_next = 1'b0;
            end
         endcase
      end
      if (capture)
      begin
         prev_next = math_result;
      end
      else if (eval_reg & math_ov32 & capture_on_overflow_en)
      begin
         prev_next = math_result;
      end
   end

   // sticky flags, a set wins over a clear
   always @*
   begin
      range_next = divide_range_error_reg & ~clr_flags;
      ov16_next  = overflow16_flag_reg & ~clr_flags;
      ov32_next  = overflow32_flag_reg & ~clr_flags;
      if (eval_reg)
      begin
         range_next = range_next | math_range;
         ov16_next  = ov16_next | math_ov16;
         ov32_next  = ov32_next | math_ov32;
      end
   end

   // read data
   always @*
   begin
      case (sfr_addr_in)
         `AUC_ADDR_CFG1:   rdata_next = {1'b0, cfg1_reg};
         `AUC_ADDR_CFG2:   rdata_next = {3'b000, unit_irq_en_reg, 1'b0,
                                         divide_range_error_reg, overflow16_flag_reg,
                                         overflow32_flag_reg};
         `AUC_ADDR_A0:     rdata_next = operand_a_reg[7:0];
         `AUC_ADDR_A1:     rdata_next = operand_a_reg[15:8];
         `AUC_ADDR_B0:     rdata_next = operand_b_reg[7:0];
         `AUC_ADDR_B0_DIV: rdata_next = operand_b_reg[7:0];
         `AUC_ADDR_B1:     rdata_next = operand_b_reg[15:8];
         `AUC_ADDR_C0:     rdata_next = get_byte(operand_c_reg, 2'd0);
         `AUC_ADDR_C1:     rdata_next = get_byte(operand_c_reg, 2'd1);
         `AUC_ADDR_C2:     rdata_next = get_byte(operand_c_reg, 2'd2);
         `AUC_ADDR_C3:     rdata_next = get_byte(operand_c_reg, 2'd3);
         `AUC_ADDR_RES0:   rdata_next = get_byte(result_reg, 2'd0);
         `AUC_ADDR_RES1:   rdata_next = get_byte(result_reg, 2'd1);
         `AUC_ADDR_RES2:   rdata_next = get_byte(result_reg, 2'd2);
         `AUC_ADDR_RES3:   rdata_next = get_byte(result_reg, 2'd3);
         `AUC_ADDR_PREV0:  rdata_next = get_byte(previous_result_reg, 2'd0);
         `AUC_ADDR_PREV1:  rdata_next = get_byte(previous_result_reg, 2'd1);
         `AUC_ADDR_PREV2:  rdata_next = get_byte(previous_result_reg, 2'd2);
         `AUC_ADDR_PREV3:  rdata_next = get_byte(previous_result_reg, 2'd3);
         default:          rdata_next = `AUC_BYTE_ZERO;
      endcase
   end

   // state registers
   always @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         cfg1_reg               <= `AUC_CFG1_RESET;
         unit_irq_en_reg        <= 1'b0;
         divide_range_error_reg <= 1'b0;
         overflow16_flag_reg    <= 1'b0;
         overflow32_flag_reg    <= 1'b0;
         divider_mode_reg       <= 1'b0;
         operand_a_reg          <= 16'h0000;
         operand_b_reg          <= 16'h0000;
         operand_c_reg          <= 32'h00000000;
         previous_result_reg    <= 32'h00000000;
         result_reg             <= 32'h00000000;
         eval_reg               <= 1'b0;
         rdata_reg              <= 8'h00;
         irq_reg                <= 1'b0;
      end
      else if (clk_en_in)
      begin
         cfg1_reg               <= cfg1_next;
         unit_irq_en_reg        <= irq_en_next;
         divide_range_error_reg <= range_next;
         overflow16_flag_reg    <= ov16_next;
         overflow32_flag_reg    <= ov32_next;
         divider_mode_reg       <= div_mode_next;
         operand_a_reg          <= a_next;
         operand_b_reg          <= b_next;
         operand_c_reg          <= c_next;
         previous_result_reg    <= prev_next;
         // result tracks operands each enabled cycle, or previous result with read-stored select
         result_reg             <= read_stored_sel ? previous_result_reg
                                                   : math_result;
         eval_reg               <= eval_next;
         rdata_reg              <= rdata_next;
         irq_reg                <= unit_irq_en_reg & divider_mode_reg &
                                   divide_range_error_reg;
      end
   end

   assign sfr_rdata_out    = rdata_reg;
   assign result_out       = result_reg;
   assign divider_mode_out = divider_mode_reg;
   assign irq_out          = irq_reg;

endmodule

`default_nettype wire

// >>> auc_core_sva.sv
// checker for the arithmetic unit control block
// assumes it is bound to auc_core and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module auc_core_sva
(
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic        clk_en_in,
   input wire logic [7:0]  sfr_addr_in,
   input wire logic        sfr_wr_in,
   input wire logic [7:0]  sfr_wdata_in,
   input wire logic [7:0]  sfr_rdata_out,
   input wire logic [31:0] result_out,
   input wire logic        divider_mode_out,
   input wire logic        irq_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   logic wr_en;
   assign wr_en = sfr_wr_in & clk_en_in;

   property p_cap_now_rd0;
      clk_en_in && sfr_addr_in == 8'hc2 |=> sfr_rdata_out[7] == 1'b0;
   endproperty
   a_cap_now_rd0: assert property (p_cap_now_rd0)
      else $error("capture-now bit read back as one");

   property p_cfg2_rd0;
      clk_en_in && sfr_addr_in == 8'hc3 |=> sfr_rdata_out[7:5] == 3'h0 && !sfr_rdata_out[3];
   endproperty
   a_cfg2_rd0: assert property (p_cfg2_rd0)
      else $error("clear field or unused bit read back as one");

   property p_rst_zero;
      $rose(rstn_in) |-> result_out == 32'h0 && !divider_mode_out && !irq_out;
   endproperty
   a_rst_zero: assert property (p_rst_zero)
      else $error("outputs not zero after reset");

   property p_div_enter;
      wr_en && sfr_addr_in == 8'hb1 |-> ##[1:2] divider_mode_out;
   endproperty
   a_div_enter: assert property (p_div_enter)
      else $error("divisor alias write did not enter divider mode");

   property p_div_leave;
      wr_en && sfr_addr_in == 8'hb2 |-> ##[1:2] !divider_mode_out;
   endproperty
   a_div_leave: assert property (p_div_leave)
      else $error("low b write did not leave divider mode");

   property p_mode_hold;
      !sfr_wr_in [*3] |=> $stable(divider_mode_out);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("divider mode changed without a write");

   property p_irq_mode;
      irq_out |-> $past(divider_mode_out);
   endproperty
   a_irq_mode: assert property (p_irq_mode)
      else $error("interrupt raised outside divider mode");

   property p_clr_all;
      wr_en && sfr_addr_in == 8'hc3 && sfr_wdata_in[7:5] == 3'h5
         |-> ##[1:3] result_out == 32'h0 && !divider_mode_out;
   endproperty
   a_clr_all: assert property (p_clr_all)
      else $error("clear-all left a nonzero result or divider mode");

   c_irq: cover property (irq_out);
   c_div: cover property (wr_en && sfr_addr_in == 8'hb1);
   c_clr: cover property (wr_en && sfr_addr_in == 8'hc3 && sfr_wdata_in[7:5] == 3'h5);
endmodule

bind auc_core auc_core_sva chk_u
(
   .clk_in           (clk_in),
   .rstn_in          (rstn_in),
   .clk_en_in        (clk_en_in),
   .sfr_addr_in      (sfr_addr_in),
   .sfr_wr_in        (sfr_wr_in),
   .sfr_wdata_in     (sfr_wdata_in),
   .sfr_rdata_out    (sfr_rdata_out),
   .result_out       (result_out),
   .divider_mode_out (divider_mode_out),
   .irq_out          (irq_out)
);
`default_nettype wire

// >>> auc_cpu_model.sv
// processor core model driving the special-function register bus
// assumes one write strobe per cycle and registered read data
`timescale 1ns/1ps
`default_nettype none
module auc_cpu_model
(
   input  wire logic       clk_in,
   input  wire logic [7:0] sfr_rdata_in,
   output var  logic [7:0] sfr_addr_out,
   output var  logic       sfr_wr_out,
   output var  logic [7:0] sfr_wdata_out
);
   initial
   begin
      sfr_addr_out  = 8'h00;
      sfr_wr_out    = 1'b0;
      sfr_wdata_out = 8'h00;
   end

   // one-cycle write strobe, data scrambled once released
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      sfr_addr_out  <= a;
      sfr_wdata_out <= d;
      sfr_wr_out    <= 1'b1;
      @(posedge clk_in);
      sfr_wr_out    <= 1'b0;
      sfr_wdata_out <= ~d;
   endtask

   // divisor low byte through the alias address
   task automatic div_lo(input logic [7:0] d);
      wr_byte(8'hb1, d);
   endtask

   task automatic rd_byte(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_in);
      sfr_addr_out <= a;
      @(posedge clk_in);
      @(posedge clk_in);
      #1 v = sfr_rdata_in;
   endtask
endmodule
`default_nettype wire

// >>> auc_defs.vh
// constants for the arithmetic unit control block
// assumes an 8-bit special-function register bus
`ifndef AUC_DEFS_VH
`define AUC_DEFS_VH

// register addresses
`define AUC_ADDR_CFG1     8'hc2
`define AUC_ADDR_CFG2     8'hc3
`define AUC_ADDR_A0       8'ha2
`define AUC_ADDR_A1       8'ha3
`define AUC_ADDR_B0       8'hb2
`define AUC_ADDR_B0_DIV   8'hb1
`define AUC_ADDR_B1       8'hb3
`define AUC_ADDR_C0       8'ha4
`define AUC_ADDR_C1       8'ha5
`define AUC_ADDR_C2       8'ha6
`define AUC_ADDR_C3       8'ha7
`define AUC_ADDR_RES0     8'hd4
`define AUC_ADDR_RES1     8'hd5
`define AUC_ADDR_RES2     8'hd6
`define AUC_ADDR_RES3     8'hd7
`define AUC_ADDR_PREV0    8'hd8
`define AUC_ADDR_PREV1    8'hd9
`define AUC_ADDR_PREV2    8'hda
`define AUC_ADDR_PREV3    8'hdb

// first configuration register fields
`define AUC_CFG1_CAP_NOW  7
`define AUC_CFG1_CAP_MAN  6
`define AUC_CFG1_OV_CAP   5
`define AUC_CFG1_RD_STORE 4
`define AUC_CFG1_ADD_HI   3
`define AUC_CFG1_ADD_LO   2
`define AUC_CFG1_MUL_HI   1
`define AUC_CFG1_MUL_LO   0

// second configuration register fields
`define AUC_CFG2_CLR_HI   7
`define AUC_CFG2_CLR_LO   5
`define AUC_CFG2_IRQ_EN   4
`define AUC_CFG2_RANGE    2
`define AUC_CFG2_OV16     1
`define AUC_CFG2_OV32     0

// reset values
`define AUC_CFG1_RESET    7'h00
`define AUC_BYTE_ZERO     8'h00

// clear command codes
`define AUC_CLR_NONE      3'h0
`define AUC_CLR_A         3'h1
`define AUC_CLR_B         3'h2
`define AUC_CLR_C         3'h3
`define AUC_CLR_PREV      3'h4
`define AUC_CLR_ALL       3'h5
`define AUC_CLR_FLAGS     3'h6

// source and command encodings
`define AUC_ADD_ZERO      2'h0
`define AUC_ADD_PREV      2'h2
`define AUC_ADD_CONCAT    2'h3
`define AUC_MUL_AA        2'h1
`define AUC_MUL_APREV     2'h2

// divider constants
`define AUC_DIV_MIN       16'h8000
`define AUC_DIV_ONES      16'hffff
`define AUC_DIV_ONE       16'h0001

`endif

// >>> auc_math.v
// combinational multiply, add and divide datapath
// assumes operands come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "auc_defs.vh"

module auc_math
(
   input  wire [15:0] operand_a_in,
   input  wire [15:0] operand_b_in,
   input  wire [31:0] operand_c_in,
   input  wire [31:0] previous_result_in,
   input  wire [1:0]  adder_source_sel_in,
   input  wire [1:0]  multiply_operand_sel_in,
   input  wire        divider_mode_in,
   output wire [31:0] math_result_out,
   output wire        overflow16_out,
   output wire        overflow32_out,
   output wire        range_error_out
);

   reg  [15:0] mul_b;
   reg  [31:0] add_b;
   wire [15:0] mul_a;
   wire [15:0] mul_b_gated;
   wire [31:0] product;
   wire [31:0] add_a;
   wire [16:0] sum_lo;
   wire [32:0] sum_full;
   wire [15:0] divider_dividend_in;
   wire [15:0] divider_divisor_in;
   wire [15:0] divisor_safe;
   wire [15:0] quotient;
   wire [15:0] remainder;

   always @*
   begin
      case (multiply_operand_sel_in)
         `AUC_MUL_AA:    mul_b = operand_a_in;
         `AUC_MUL_APREV: mul_b = previous_result_in[15:0];
         default:        mul_b = operand_b_in;
      endcase
   end

   always @*
   begin
      case (adder_source_sel_in)
         `AUC_ADD_ZERO: add_b = 32'h00000000;
         `AUC_ADD_PREV: add_b = previous_result_in;
         default:       add_b = operand_c_in;
      endcase
   end

   // multiplier inputs zero in divider mode
   assign mul_a       = divider_mode_in ? 16'h0000 : operand_a_in;
   assign mul_b_gated = divider_mode_in ? 16'h0000 : mul_b;
   assign product     = $signed(mul_a) * $signed(mul_b_gated);

   // a above b when concatenated
   assign add_a = (adder_source_sel_in == `AUC_ADD_CONCAT) ?
                  {operand_a_in, operand_b_in} : product;

   assign sum_lo   = {1'b0, add_a[15:0]} + {1'b0, add_b[15:0]};
   assign sum_full = {1'b0, add_a} + {1'b0, add_b};

   assign overflow32_out = ~divider_mode_in & sum_full[32];
   assign overflow16_out = ~divider_mode_in & (sum_lo[16] | sum_full[32]);

   // divider idles at 0 / 1 in multiplier mode
   assign divider_dividend_in = divider_mode_in ? operand_a_in : 16'h0000;
   assign divider_divisor_in  = divider_mode_in ? operand_b_in : `AUC_DIV_ONE;

   assign range_error_out = divider_mode_in &
                            ((divider_divisor_in == 16'h0000) |
                             ((divider_dividend_in == `AUC_DIV_MIN) &
                              (divider_divisor_in == `AUC_DIV_ONES)));

   assign divisor_safe = range_error_out ? `AUC_DIV_ONE : divider_divisor_in;
   // signed zero keeps the divide itself signed
   assign quotient     = range_error_out ? 16'sh0000 :
                         $signed(divider_dividend_in) / $signed(divisor_safe);
   assign remainder    = range_error_out ? 16'sh0000 :
                         $signed(divider_dividend_in) % $signed(divisor_safe);

   assign math_result_out = divider_mode_in ? {remainder, quotient} : sum_full[31:0];

endmodule

`default_nettype wire
